// *** core/uis_irq_core.sv ***
// Overview of operation
// - after reset tx, rts high, irq idle
// - eight enabled sources drive active-low irq
// - id field reads 00 0001 when idle
// - line status: priority 1, code 06
// - receive time-out: priority 2, code 0c
// - receive data: priority 2, code 04
// - transmit holding: priority 3, code 02
// - modem change: priority 4, code 00
// - io input change: priority 5, code 0e
// - flow-stop/special char: priority 6, code 10
// - rts/cts low-to-high: priority 7, code 20
// - fifo error flag while errors remain
// - head char status, zero when empty
// - flow-stop cleared by resume; special char by ident read
// - ier[3:0] zero gives polled mode
// - sleep needs enhanced bit and ier bit
// - sleep only when idle and empty
// - sleep stops clock; wake on activity
// - time-out after four character times
// - break: rx low beyond character time
// - break bit forces tx low
// - flow-stop flag gated by its enable
`timescale 1ns/1ps
`default_nettype none
module uis_irq_core (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_interrupt_enable_reg,
	input wire logic [uis_pkg::GPIO_N-1:0] i_io_pin_irq_enable_reg,
	input wire logic [uis_pkg::GPIO_N-1:0] i_io_dir_out,
	input wire logic [7:0] i_enhanced_features_reg,
	input wire logic [7:0] i_line_control_reg,
	input wire logic i_fifo_en,
	input wire logic i_ident_rd,
	input wire logic i_rx_fifo_rd,
	input wire logic i_rx_empty,
	input wire logic i_rx_above_trig,
	input wire logic [2:0] i_head_status,
	input wire logic i_err_in_fifo,
	input wire logic i_overrun,
	input wire logic i_rx_stop_center,
	input wire logic i_rx_in,
	input wire logic i_bit_tick,
	input wire logic [3:0] i_char_bits,
	input wire logic i_tx_data,
	input wire logic i_tx_trig,
	input wire logic i_tx_empty,
	input wire logic i_tx_fifo_wr,
	input wire logic [3:0] i_modem_in,
	input wire logic [uis_pkg::GPIO_N-1:0] i_io_in,
	input wire logic i_xoff_det,
	input wire logic i_xon_det,
	input wire logic i_special_det,
	input wire logic i_rts_n,
	input wire logic i_cts_n,
	output logic o_irq_n,
	output logic o_irq_oe,
	output logic [5:0] o_interrupt_ident_reg,
	output logic [7:0] o_line_status_reg,
	output logic o_tx_out,
	output logic o_rts_n,
	output logic [uis_pkg::GPIO_N-1:0] o_io_oe,
	output logic o_sleeping,
	output logic o_clk_run
);
	import uis_pkg::*;

	//--------------------------------------------------
	// source latches
	//--------------------------------------------------
	logic [3:0] modem_d_reg;
	logic [GPIO_N-1:0] io_d_reg;
	logic rts_d_reg, cts_d_reg, rx_d_reg;
	logic msr_pend_reg, io_pend_reg, hsk_pend_reg;
	logic xof_flow_reg, xof_spec_reg, thr_pend_reg, tx_data_d_reg;
	logic modem_chg, io_chg, hsk_rise;
	logic [GPIO_N-1:0] io_bit_chg;
	genvar g;

	generate
		for (g = 0; g < GPIO_N; g++) begin : g_io
			assign io_bit_chg[g] = (io_d_reg[g] ^ i_io_in[g]) &
				~i_io_dir_out[g] & i_io_pin_irq_enable_reg[g];
		end
	endgenerate

	assign modem_chg = |(modem_d_reg ^ i_modem_in);
	assign io_chg = |io_bit_chg;
	assign hsk_rise = (~rts_d_reg & i_rts_n) | (~cts_d_reg & i_cts_n);

	// pin delay regs start at idle levels so reset makes no false pin edge; tx_data_d_reg starts low, so a high i_tx_data reads as an edge
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			modem_d_reg <= 4'hf;
			io_d_reg <= '0;
			rts_d_reg <= 1'b1;
			cts_d_reg <= 1'b1;
			rx_d_reg <= 1'b1;
			tx_data_d_reg <= 1'b0;
		end else begin
			modem_d_reg <= i_modem_in;
			io_d_reg <= i_io_in;
			rts_d_reg <= i_rts_n;
			cts_d_reg <= i_cts_n;
			rx_d_reg <= i_rx_in;
			tx_data_d_reg <= i_tx_data;
		end
	end

	// sticky events cleared by an ident read; set wins over clear
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			msr_pend_reg <= 1'b0;
			io_pend_reg <= 1'b0;
			hsk_pend_reg <= 1'b0;
			xof_spec_reg <= 1'b0;
		end else begin
			msr_pend_reg <= modem_chg | (msr_pend_reg & ~i_ident_rd);
			io_pend_reg <= io_chg | (io_pend_reg & ~i_ident_rd);
			hsk_pend_reg <= hsk_rise | (hsk_pend_reg & ~i_ident_rd);
			xof_spec_reg <= i_special_det |
				(xof_spec_reg & ~i_ident_rd);
		end
	end

	// flow-stop from flow characters clears only on resume
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			xof_flow_reg <= 1'b0;
		else
			xof_flow_reg <= i_xoff_det | (xof_flow_reg & ~i_xon_det);
	end

	// transmit holding: raised on becoming ready, dropped by read or write
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			thr_pend_reg <= 1'b0;
		else if (i_tx_data & ~tx_data_d_reg)
			thr_pend_reg <= 1'b1;
		else if (i_ident_rd | i_tx_fifo_wr)
			thr_pend_reg <= 1'b0;
	end

	//--------------------------------------------------
	// receive time-out and break timers
	//--------------------------------------------------
	logic [5:0] rto_cnt_reg, brk_cnt_reg;
	logic rto_pend_reg, brk_det_reg;
	logic [5:0] rto_limit;
	logic rx_idle;

	assign rto_limit = 6'(i_char_bits * RTO_CHARS);
	assign rx_idle = i_rx_in & (brk_cnt_reg == 6'h00);

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rto_cnt_reg <= '0;
			rto_pend_reg <= 1'b0;
		end else if (i_rx_stop_center | i_rx_fifo_rd | i_rx_empty) begin
			rto_cnt_reg <= '0;
			rto_pend_reg <= 1'b0;
		end else if (i_bit_tick & ~rto_pend_reg & ~i_rx_above_trig) begin
			if (rto_cnt_reg + 6'h01 >= rto_limit)
				rto_pend_reg <= 1'b1;
			rto_cnt_reg <= rto_cnt_reg + 6'h01;
		end
	end

	// break: low for longer than a whole framed character
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			brk_cnt_reg <= '0;
			brk_det_reg <= 1'b0;
		end else if (i_rx_in) begin
			brk_cnt_reg <= '0;
			brk_det_reg <= 1'b0;
		// saturate: a line stuck low must not wrap and re-arm
		end else if (i_bit_tick && brk_cnt_reg != 6'h3f) begin
			brk_cnt_reg <= brk_cnt_reg + 6'h01;
			if (brk_cnt_reg >= {2'b00, i_char_bits})
				brk_det_reg <= 1'b1;
		end
	end

	//--------------------------------------------------
	// priority encoder
	//--------------------------------------------------
	logic [7:0] interrupt_enable_reg;
	logic lsr_act, rto_act, rxd_act, thr_act, msr_act, xof_act, hsk_act;
	logic io_act, other_act;
	logic any_act;
	logic [5:0] iid_next;

	assign interrupt_enable_reg = i_interrupt_enable_reg;
	assign lsr_act = interrupt_enable_reg[IE_LSR] & (i_err_in_fifo | i_overrun |
		brk_det_reg);
	assign rto_act = interrupt_enable_reg[IE_RXD] & rto_pend_reg;
	assign rxd_act = interrupt_enable_reg[IE_RXD] & (i_fifo_en ? i_rx_above_trig :
		~i_rx_empty);
	assign thr_act = interrupt_enable_reg[IE_THR] & thr_pend_reg &
		(i_fifo_en ? i_tx_trig : i_tx_data);
	assign msr_act = interrupt_enable_reg[IE_MSR] & msr_pend_reg;
	assign xof_act = interrupt_enable_reg[IE_XOF] & (xof_flow_reg | xof_spec_reg);
	assign hsk_act = interrupt_enable_reg[IE_HSK] & hsk_pend_reg;
	// io stops asserting, pending or not, once no input pin has its enable set
	assign io_act = io_pend_reg &
		|(i_io_pin_irq_enable_reg & ~i_io_dir_out);

	always_comb begin
		// lowest priority number wins
		iid_next = IID_NONE;
		if (lsr_act) iid_next = IID_LSR;
		else if (rto_act) iid_next = IID_RTO;
		else if (rxd_act) iid_next = IID_RXD;
		else if (thr_act) iid_next = IID_THR;
		else if (msr_act) iid_next = IID_MSR;
		else if (io_act) iid_next = IID_IOP;
		else if (xof_act) iid_next = IID_XOF;
		else if (hsk_act) iid_next = IID_HSK;
	end

	// polled mode: all ier[3:0] clear leaves those sources silent
	assign any_act = iid_next != IID_NONE;

	// thr alone may stay pending across sleep; any other source blocks it
	assign other_act = lsr_act | rto_act | rxd_act | msr_act | io_act |
		xof_act | hsk_act;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_interrupt_ident_reg <= RESET_IID;
			o_irq_n <= 1'b1;
			o_irq_oe <= 1'b0;
		end else begin
			o_interrupt_ident_reg <= iid_next;
			o_irq_n <= ~any_act;
			o_irq_oe <= any_act;
		end
	end

	//--------------------------------------------------
	// line status
	//--------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_line_status_reg <= RESET_LSR;
		else begin
			o_line_status_reg[7] <= i_err_in_fifo;
			o_line_status_reg[6] <= i_tx_empty;
			o_line_status_reg[5] <= i_tx_data;
			o_line_status_reg[4:2] <= i_rx_empty ? 3'h0 : i_head_status;
			o_line_status_reg[1] <= i_overrun;
			o_line_status_reg[0] <= ~i_rx_empty;
		end
	end

	//--------------------------------------------------
	// sleep
	//--------------------------------------------------
	uis_pwr_t pwr_reg;
	logic sleep_ok, wake;

	assign sleep_ok = i_enhanced_features_reg[EF_ENH] & interrupt_enable_reg[IE_SLEEP];
	assign wake = (rx_d_reg ^ i_rx_in) | modem_chg | i_tx_fifo_wr;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			pwr_reg <= UIS_AWAKE;
		else begin
			case (pwr_reg)
				UIS_AWAKE: begin
					if (sleep_ok && rx_idle && i_tx_empty && i_rx_empty &&
						!other_act && !wake)
						pwr_reg <= UIS_ASLEEP;
				end
				UIS_ASLEEP: begin
					if (wake || !sleep_ok)
						pwr_reg <= UIS_AWAKE;
				end
				default: pwr_reg <= UIS_AWAKE;
			endcase
		end
	end

	//--------------------------------------------------
	// output pins
	//--------------------------------------------------

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_tx_out <= 1'b1;
			o_rts_n <= 1'b1;
			o_io_oe <= '0;
		end else begin
			o_tx_out <= ~i_line_control_reg[LC_BRK] & i_tx_data;
			o_rts_n <= i_rts_n;
			o_io_oe <= i_io_dir_out;
		end
	end

	// divisor writes while asleep are the host's to avoid
	assign o_sleeping = pwr_reg == UIS_ASLEEP;
	assign o_clk_run = pwr_reg != UIS_ASLEEP;
endmodule : uis_irq_core
`default_nettype wire

// *** shared/uis_pkg.sv ***
package uis_pkg;
	// identification codes, 6-bit field
	localparam logic [5:0] IID_NONE = 6'h01;
	localparam logic [5:0] IID_LSR = 6'h06;
	localparam logic [5:0] IID_RTO = 6'h0c;
	localparam logic [5:0] IID_RXD = 6'h04;
	localparam logic [5:0] IID_THR = 6'h02;
	localparam logic [5:0] IID_MSR = 6'h00;
	localparam logic [5:0] IID_IOP = 6'h0e;
	localparam logic [5:0] IID_XOF = 6'h10;
	localparam logic [5:0] IID_HSK = 6'h20;
	// interrupt enable, enhanced feature and line control field positions
	localparam int IE_RXD = 0;
	localparam int IE_THR = 1;
	localparam int IE_LSR = 2;
	localparam int IE_MSR = 3;
	localparam int IE_SLEEP = 4;
	localparam int IE_XOF = 5;
	localparam int IE_HSK = 6;
	localparam int EF_ENH = 4;
	localparam int LC_BRK = 6;
	// time-out in character times; bit times per char are an input
	localparam logic [2:0] RTO_CHARS = 3'h4;
	localparam logic [5:0] RESET_IID = 6'h01;
	localparam logic [7:0] RESET_LSR = 8'h60;
	localparam int GPIO_N = 8;
	typedef enum logic [1:0] {
		UIS_AWAKE = 2'b00,
		UIS_ASLEEP = 2'b01
	} uis_pwr_t;
endpackage : uis_pkg

// *** testbench/uis_irq_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module uis_irq_monitor (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_interrupt_enable_reg,
	input wire logic [uis_pkg::GPIO_N-1:0] i_io_pin_irq_enable_reg,
	input wire logic [7:0] i_enhanced_features_reg,
	input wire logic [7:0] i_line_control_reg,
	input wire logic i_rx_empty,
	input wire logic i_err_in_fifo,
	input wire logic i_tx_empty,
	input wire logic o_irq_n,
	input wire logic [5:0] o_interrupt_ident_reg,
	input wire logic [7:0] o_line_status_reg,
	input wire logic o_tx_out,
	input wire logic o_sleeping
);
	import uis_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_err_held;
		(i_interrupt_enable_reg[IE_LSR] && i_err_in_fifo) [*3];
	endsequence
	sequence s_all_off;
		(i_interrupt_enable_reg == 8'h00 &&
			i_io_pin_irq_enable_reg == 8'h00) [*3];
	endsequence
	property p_lsr_first;
		s_err_held |-> o_interrupt_ident_reg == IID_LSR;
	endproperty
	a_lsr_first: assert property (p_lsr_first)
		else $error("line status not reported first");
	property p_none;
		o_interrupt_ident_reg == IID_NONE |-> o_irq_n;
	endproperty
	a_none: assert property (p_none)
		else $error("irq low with idle ident");
	property p_pend;
		o_interrupt_ident_reg != IID_NONE |-> !o_irq_n;
	endproperty
	a_pend: assert property (p_pend)
		else $error("irq high with pending ident");
	property p_polled;
		s_all_off |-> o_irq_n;
	endproperty
	a_polled: assert property (p_polled)
		else $error("irq low with all enables off");
	property p_brk;
		i_line_control_reg[LC_BRK] |=> !o_tx_out;
	endproperty
	a_brk: assert property (p_brk)
		else $error("tx high during break");
	property p_head_zero;
		i_rx_empty |=> o_line_status_reg[4:2] == 3'h0;
	endproperty
	a_head_zero: assert property (p_head_zero)
		else $error("head status not zero when empty");
	property p_sleep_ok;
		$rose(o_sleeping) |-> $past(i_rx_empty && i_tx_empty);
	endproperty
	a_sleep_ok: assert property (p_sleep_ok)
		else $error("sleep entered while busy");
	property p_sleep_en;
		o_sleeping |-> $past(i_interrupt_enable_reg[IE_SLEEP] &&
			i_enhanced_features_reg[EF_ENH]);
	endproperty
	a_sleep_en: assert property (p_sleep_en)
		else $error("sleep without both enables");
endmodule : uis_irq_monitor
bind uis_irq_core uis_irq_monitor mon_u (.*);
`default_nettype wire

// *** testbench/uis_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module uis_host_model (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_auto,
	input wire logic [3:0] i_delay,
	input wire logic i_irq_n,
	output logic o_ident_rd
);
	logic [3:0] wait_reg;
	// only ident reads; divisor bytes never written, asleep or awake
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wait_reg <= 4'h0;
			o_ident_rd <= 1'b0;
		end else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
			// gap of three after the read lets irq settle
			o_ident_rd <= (wait_reg == 4'h4);
		end else begin
			o_ident_rd <= 1'b0;
			if (i_auto && !i_irq_n) begin
				wait_reg <= i_delay + 4'h4;
			end
		end
	end
endmodule : uis_host_model
`default_nettype wire

// *** testbench/uart_irq_sleep_break_logic_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module uart_irq_sleep_break_logic_tb_top;
	import uis_pkg::*;
	int compares = 0;
	int num_errors = 0;
	logic clk = 0, rst = 1, fen = 0, rd = 0, rxe = 1, trig = 0, err = 0;
	logic rxin = 1, tick = 1, txd = 0, txe = 1, txw = 0, xoff = 0, xon = 0;
	logic spc = 0, cts = 0, aut = 0, ttr = 0, ird, irq_n, tx, rts, slp, crun;
	logic stc = 0, rin = 1, oe;
	logic [7:0] interrupt_enable_reg = 0, ioen = 0, enhanced_features_reg = 0, line_control_reg = 0, ioin = 0, line_status_reg, iooe;
	logic [7:0] iodir = 0;
	logic [3:0] modem = 4'hf, dly = 0;
	logic [2:0] head = 0;
	logic [5:0] id;
	uis_irq_core dut_u (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_interrupt_enable_reg(interrupt_enable_reg), .i_io_pin_irq_enable_reg(ioen),
		.i_io_dir_out(iodir), .i_enhanced_features_reg(enhanced_features_reg),
		.i_line_control_reg(line_control_reg), .i_fifo_en(fen), .i_ident_rd(ird),
		.i_rx_fifo_rd(rd), .i_rx_empty(rxe), .i_rx_above_trig(trig),
		.i_head_status(head), .i_err_in_fifo(err), .i_overrun(1'b0),
		.i_rx_stop_center(stc), .i_rx_in(rxin), .i_bit_tick(tick),
		.i_char_bits(4'h4), .i_tx_data(txd), .i_tx_trig(ttr),
		.i_tx_empty(txe), .i_tx_fifo_wr(txw), .i_modem_in(modem),
		.i_io_in(ioin), .i_xoff_det(xoff), .i_xon_det(xon),
		.i_special_det(spc), .i_rts_n(rin), .i_cts_n(cts),
		.o_irq_n(irq_n), .o_irq_oe(oe), .o_interrupt_ident_reg(id),
		.o_line_status_reg(line_status_reg), .o_tx_out(tx), .o_rts_n(rts),
		.o_io_oe(iooe), .o_sleeping(slp), .o_clk_run(crun));
	uis_host_model host_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_auto(aut),
		.i_delay(dly), .i_irq_n(irq_n), .o_ident_rd(ird));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	task automatic step(input logic [5:0] code);
		cyc(3);
		`CHK(id, code)
		`CHK(irq_n, code == IID_NONE)
		`CHK(oe, code != IID_NONE)
	endtask : step
	task automatic conclude;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
	initial begin
		cyc(4);
		`CHK({tx, rts, iooe}, {2'b11, 8'h00})
		`CHK({irq_n, oe, id}, {2'b10, IID_NONE})
		`CHK(line_status_reg, RESET_LSR)
		cyc(1);
		rst = 0;
		$display("test reset done");
		interrupt_enable_reg = 8'h6f; ioen = 8'hff; fen = 1; err = 1; trig = 1; rxe = 0;
		txd = 1; ttr = 1; modem = 4'he; ioin = 8'h01;
		pulse(xoff);
		step(IID_LSR);
		err = 0; cts = 1;
		step(IID_RXD);
		trig = 0; rxe = 1;
		step(IID_THR);
		pulse(txw);
		step(IID_MSR);
		interrupt_enable_reg[3] = 0;
		step(IID_IOP);
		ioen = 0;
		step(IID_XOF);
		interrupt_enable_reg[5] = 0;
		step(IID_HSK);
		aut = 1; cyc(8); aut = 0;
		step(IID_NONE);
		ioen = 8'h02; iodir = 8'h02; ioin = 8'h03;
		step(IID_NONE);
		`CHK(iooe, 8'h02)
		ioen = 0;
		interrupt_enable_reg[5] = 1;
		step(IID_XOF);
		pulse(xon);
		step(IID_NONE);
		pulse(spc);
		step(IID_XOF);
		dly = 4'h5; aut = 1; cyc(12); aut = 0;
		step(IID_NONE);
		rin = 0; cyc(2);
		`CHK(rts, 1'b0)
		rin = 1;
		step(IID_HSK);
		aut = 1; cyc(8); aut = 0;
		step(IID_NONE);
		$display("test priority done");
		interrupt_enable_reg = 0; err = 1; head = 3'h5; rxe = 0; txd = 0; cyc(1); txd = 1;
		step(IID_NONE);
		`CHK(line_status_reg[7], 1'b1)
		`CHK(line_status_reg[4:2], 3'h5)
		rxe = 1; err = 0; cyc(2);
		`CHK(line_status_reg[7], 1'b0)
		`CHK(line_status_reg[4:2], 3'h0)
		interrupt_enable_reg = 8'h01; rxe = 0; cyc(12);
		`CHK(id, IID_NONE)
		pulse(stc); cyc(12);
		`CHK(id, IID_NONE)
		cyc(10);
		`CHK(id, IID_RTO)
		pulse(rd); cyc(3);
		`CHK(id, IID_NONE)
		rxe = 1;
		$display("test status and time-out done");
		line_control_reg = 8'h40; cyc(3);
		`CHK(tx, 1'b0)
		line_control_reg = 0; cyc(2);
		`CHK(tx, 1'b1)
		interrupt_enable_reg = 8'h04; rxin = 0; cyc(4);
		`CHK(id, IID_NONE)
		cyc(4);
		`CHK(id, IID_LSR)
		rxin = 1;
		$display("test break done");
		rst = 1; cyc(2); rst = 0;
		interrupt_enable_reg = 8'h10; cyc(4);
		`CHK(slp, 1'b0)
		enhanced_features_reg = 8'h10; cyc(3);
		`CHK({slp, crun}, 2'b10)
		txe = 0; pulse(txw); cyc(2);
		`CHK(slp, 1'b0)
		txe = 1; rxe = 0; cyc(4);
		`CHK(slp, 1'b0)
		$display("test sleep done");
		conclude();
	end
endmodule : uart_irq_sleep_break_logic_tb_top
`default_nettype wire
